//--- sbsd_top.sv
// Serial peripheral core: bit-rate generator, status flags and data buffers.
// Assumes one system clock; pins SCK, MISO and select arrive asynchronously.
// Function
// - Prescale code n divides by n+1.
// - Rate code n divides by 2^(n+1).
// - Bus clock, prescaler, divider, master bit clock.
// - Status unused bits zero, writes ignored.
// - Receive-full sets when byte reaches buffer.
// - Receive-full clears: status read, data read.
// - Tx-empty high when room; status read, write clears.
// - Unarmed data write is discarded.
// - Tx interrupt while empty and enabled.
// - Tx-empty sets when byte enters shifter.
// - Idle unit loads shifter within two cycles.
// - Shift done: queued byte loads, else nothing.
// - Fault flag sets when master select low.
// - Fault only master, enabled, no select output.
// - Fault clears: status read, control one write.
// - Data read gives rx buffer; write tx buffer.
// - Master write starts a transfer.
// - Overrun keeps old byte, drops new.
// - Interrupt on rx-full or fault when enabled.
// - No overrun indication at all.
`timescale 1ns/1ps
module sbsd_top import sbsd_pkg::*; (
	input wire logic SYS_CLK_I, // System bus clock.
	input wire logic RESET_N_I, // Asynchronous reset, active low.
	input wire logic CE_I, // Clock enable, freezes state when low.
	input wire logic [2:0] ADDR_I, // Register address.
	input wire logic [7:0] WDATA_I, // Write data.
	input wire logic WR_I, // Write strobe.
	input wire logic RD_I, // Read strobe.
	output logic [7:0] RDATA_O, // Read data, one cycle after strobe.
	output logic IRQ_O, // Interrupt request, active high.
	output logic SCK_O, // Serial clock out in master mode.
	output logic SCK_OE_O, // Serial clock output enable.
	output logic MOSI_O, // Master data out.
	output logic MOSI_OE_O, // Master data output enable.
	output logic MISO_O, // Slave data out.
	output logic MISO_OE_O, // Slave data output enable.
	output logic SS_N_O, // Select output, active low.
	output logic SS_OE_O, // Select output enable.
	input wire logic SCK_I, // Serial clock pin.
	input wire logic MOSI_I, // Master data pin.
	input wire logic MISO_I, // Slave data pin.
	input wire logic SS_N_I // Select pin, active low.
);
	logic [7:0] control_reg_one;
	logic [7:0] ctrl_two;
	logic [7:0] bit_rate_select;
	logic rx_full_flag;
	logic tx_empty_flag;
	logic mode_fault_flag;
	logic [7:0] rx_buf;
	logic [7:0] tx_buf;
	logic [7:0] shifter;
	logic shift_busy;
	logic [3:0] bit_cnt;
	logic rx_armed;
	logic tx_armed;
	logic fault_armed;
	logic sample_bit;
	logic [1:0] sck_sync;
	logic [1:0] mosi_sync;
	logic [1:0] miso_sync;
	logic [1:0] ss_sync;
	logic sck_prev;
	logic ss_prev;
	sbsd_state_t state;
	logic half_tick;
	logic master_select;
	logic mode_fault_enable;
	logic select_output_enable;
	logic unit_on;
	logic tx_irq_enable;
	logic rx_fault_irq_enable;
	logic [7:0] status_view;
	logic st_rd;
	logic data_rd;
	logic data_wr;
	logic c1_wr;
	logic data_accept;
	logic load_shifter;
	logic xfer_done;
	logic slave_rise;
	logic slave_fall;
	logic fault_event;
	logic rx_take;
	logic slave_cut;

	assign master_select = control_reg_one[C1_MASTER];
	assign unit_on = control_reg_one[C1_ENABLE];
	assign tx_irq_enable = control_reg_one[C1_TX_IE];
	assign rx_fault_irq_enable = control_reg_one[C1_RX_FAULT_IE];
	assign select_output_enable = control_reg_one[C1_SEL_OE];
	assign mode_fault_enable = ctrl_two[C2_FAULT_EN];

	// Register port decode; strobes are single-cycle from the master.
	assign st_rd = RD_I && (ADDR_I == ADDR_STATUS);
	assign data_rd = RD_I && (ADDR_I == ADDR_DATA);
	assign data_wr = WR_I && (ADDR_I == ADDR_DATA);
	assign c1_wr = WR_I && (ADDR_I == ADDR_CTRL_ONE);
	assign data_accept = data_wr && tx_armed && tx_empty_flag;

	always_comb begin
		status_view = 8'h00;
		status_view[ST_RX_FULL] = rx_full_flag;
		status_view[ST_TX_EMPTY] = tx_empty_flag;
		status_view[ST_FAULT] = mode_fault_flag;
	end

	// Pin synchronisers; the first stage feeds only the second.
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			sck_sync <= 2'b00;
			mosi_sync <= 2'b00;
			miso_sync <= 2'b00;
			ss_sync <= 2'b11;
		end else if (CE_I) begin
			sck_sync <= {sck_sync[0], SCK_I};
			mosi_sync <= {mosi_sync[0], MOSI_I};
			miso_sync <= {miso_sync[0], MISO_I};
			ss_sync <= {ss_sync[0], SS_N_I};
		end
	end

	// Edge history taken from the second synchroniser stage only.
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			sck_prev <= 1'b0;
			ss_prev <= 1'b1;
		end else if (CE_I) begin
			sck_prev <= sck_sync[1];
			ss_prev <= ss_sync[1];
		end
	end

	// Slave mode uses a fixed format: sample rising, shift falling.
	assign slave_rise = !master_select && unit_on && !ss_sync[1] && sck_sync[1] && !sck_prev;
	assign slave_fall = !master_select && unit_on && !ss_sync[1] && !sck_sync[1] && sck_prev;

	sbsd_rate_div u_rate_div (
		.clk_i(SYS_CLK_I),
		.rst_n_i(RESET_N_I),
		.ce_i(CE_I),
		.run_i(state != SB_IDLE),
		.presc_code_i(bit_rate_select[PRESC_LSB +: 3]),
		.rate_code_i(bit_rate_select[RATE_LSB +: 3]),
		.half_tick_o(half_tick)
	);

	// Idle shifter takes the byte next cycle.
	assign load_shifter = !tx_empty_flag && !shift_busy && unit_on;
	assign xfer_done = shift_busy && (bit_cnt == BITS_PER_BYTE) &&
		((state == SB_HIGH && half_tick) || (slave_fall) || (!master_select && ss_sync[1]));
	// A full buffer takes a new byte only when read in that same cycle.
	assign rx_take = xfer_done && (!rx_full_flag || (data_rd && rx_armed));
	// A select rise before the eighth bit drops a cut slave frame, so the engine never hangs.
	assign slave_cut = !master_select && shift_busy && ss_sync[1] && !ss_prev;

	// Control and bit-rate registers, software written.
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			control_reg_one <= CTRL_ONE_RST;
			ctrl_two <= CTRL_TWO_RST;
			bit_rate_select <= BIT_RATE_RST;
		end else if (CE_I && WR_I) begin
			if (ADDR_I == ADDR_CTRL_ONE) begin
				control_reg_one <= WDATA_I;
			end
			if (ADDR_I == ADDR_CTRL_TWO) begin
				ctrl_two <= WDATA_I & CTRL_TWO_MASK;
			end
			if (ADDR_I == ADDR_BIT_RATE) begin
				bit_rate_select <= WDATA_I & BIT_RATE_MASK;
			end
		end
	end

	// Read data stands one cycle after the strobe and only then.
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			RDATA_O <= 8'h00;
		end else if (CE_I) begin
			RDATA_O <= 8'h00;
			if (RD_I) begin
				case (ADDR_I)
					ADDR_CTRL_ONE: RDATA_O <= control_reg_one;
					ADDR_CTRL_TWO: RDATA_O <= ctrl_two;
					ADDR_BIT_RATE: RDATA_O <= bit_rate_select;
					ADDR_STATUS: RDATA_O <= status_view;
					ADDR_DATA: RDATA_O <= rx_buf;
					default: RDATA_O <= 8'h00;
				endcase
			end
		end
	end

	// Arming bits remember a status read that saw each flag set.
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			rx_armed <= 1'b0;
			tx_armed <= 1'b0;
			fault_armed <= 1'b0;
		end else if (CE_I) begin
			if (st_rd) begin
				rx_armed <= rx_full_flag;
				tx_armed <= tx_empty_flag;
				fault_armed <= mode_fault_flag;
			end else begin
				if (data_rd) begin
					rx_armed <= 1'b0;
				end
				if (data_wr) begin
					tx_armed <= 1'b0;
				end
				if (c1_wr) begin
					fault_armed <= 1'b0;
				end
			end
		end
	end

	// Set on completion; set beats the clear.
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			rx_full_flag <= 1'b0;
			rx_buf <= 8'h00;
		end else if (CE_I) begin
			if (rx_take) begin
				rx_full_flag <= 1'b1;
				// The eighth sample has not been shifted in yet, so it is appended here.
				rx_buf <= {shifter[6:0], sample_bit};
			end else if (data_rd && rx_armed) begin
				rx_full_flag <= 1'b0;
			end
			// Overrun keeps the old byte; nothing records it.
		end
	end

	// Armed write clears; load sets again.
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			tx_empty_flag <= 1'b1;
			tx_buf <= 8'h00;
		end else if (CE_I) begin
			if (load_shifter) begin
				tx_empty_flag <= 1'b1;
			end else if (data_accept) begin
				tx_empty_flag <= 1'b0;
				tx_buf <= WDATA_I;
			end
		end
	end

	// Select low in master mode; only this configuration.
	assign fault_event = master_select && mode_fault_enable && !select_output_enable &&
		unit_on && !ss_sync[1];

	// Armed control-one write clears; a new fault wins.
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			mode_fault_flag <= 1'b0;
		end else if (CE_I) begin
			if (fault_event) begin
				mode_fault_flag <= 1'b1;
			end else if (c1_wr && fault_armed) begin
				mode_fault_flag <= 1'b0;
			end
		end
	end

	// Shift engine. Master starts when a byte loads.
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			state <= SB_IDLE;
			shift_busy <= 1'b0;
			shifter <= 8'h00;
			bit_cnt <= 4'h0;
			sample_bit <= 1'b0;
		end else if (CE_I) begin
			if (load_shifter) begin
				// Queued byte moves in after a shift.
				shifter <= tx_buf;
				shift_busy <= 1'b1;
				bit_cnt <= 4'h0;
				state <= master_select ? SB_LOW : SB_IDLE;
			end else if (xfer_done || fault_event || slave_cut) begin
				// The half tick that ends the frame is taken by this branch, so the last sample goes in here.
				shifter <= {shifter[6:0], sample_bit};
				shift_busy <= 1'b0;
				state <= SB_IDLE;
			end else if (state == SB_LOW && half_tick) begin
				sample_bit <= miso_sync[1];
				bit_cnt <= bit_cnt + 4'h1;
				state <= SB_HIGH;
			end else if (state == SB_HIGH && half_tick) begin
				shifter <= {shifter[6:0], sample_bit};
				state <= SB_LOW;
			end else if (slave_rise) begin
				sample_bit <= mosi_sync[1];
				bit_cnt <= bit_cnt + 4'h1;
			end else if (slave_fall) begin
				shifter <= {shifter[6:0], sample_bit};
			end
		end
	end

	// Pin drivers registered; master clock idles low.
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			SCK_O <= 1'b0;
			SCK_OE_O <= 1'b0;
			MOSI_O <= 1'b0;
			MOSI_OE_O <= 1'b0;
			MISO_O <= 1'b0;
			MISO_OE_O <= 1'b0;
			SS_N_O <= 1'b1;
			SS_OE_O <= 1'b0;
		end else if (CE_I) begin
			SCK_O <= (state == SB_HIGH);
			SCK_OE_O <= unit_on && master_select;
			MOSI_O <= shifter[7];
			MOSI_OE_O <= unit_on && master_select;
			MISO_O <= shifter[7];
			MISO_OE_O <= unit_on && !master_select && !ss_sync[1];
			SS_N_O <= !shift_busy;
			SS_OE_O <= unit_on && master_select && mode_fault_enable && select_output_enable;
		end
	end

	// Transmit request; receive or fault request.
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			IRQ_O <= 1'b0;
		end else if (CE_I) begin
			IRQ_O <= (tx_empty_flag && tx_irq_enable) ||
				((rx_full_flag || mode_fault_flag) && rx_fault_irq_enable);
		end
	end
endmodule : sbsd_top

//--- sbsd_pkg.sv
// Package for the serial bit-rate, status and data block.
// Assumes a single system clock domain; shared by the top and the divider.
package sbsd_pkg;
	// Register offsets on the plain register port.
	localparam logic [2:0] ADDR_CTRL_ONE = 3'h0;
	localparam logic [2:0] ADDR_CTRL_TWO = 3'h1;
	localparam logic [2:0] ADDR_BIT_RATE = 3'h2;
	localparam logic [2:0] ADDR_STATUS = 3'h3;
	localparam logic [2:0] ADDR_DATA = 3'h5;
	// Field positions in the bit-rate register.
	localparam int PRESC_LSB = 4;
	localparam int RATE_LSB = 0;
	// Control register one fields.
	localparam int C1_RX_FAULT_IE = 7;
	localparam int C1_ENABLE = 6;
	localparam int C1_TX_IE = 5;
	localparam int C1_MASTER = 4;
	localparam int C1_SEL_OE = 1;
	// Control register two fields.
	localparam int C2_FAULT_EN = 4;
	// Status register fields.
	localparam int ST_RX_FULL = 7;
	localparam int ST_TX_EMPTY = 5;
	localparam int ST_FAULT = 4;
	// Reset values.
	localparam logic [7:0] CTRL_ONE_RST = 8'h04;
	localparam logic [7:0] CTRL_TWO_RST = 8'h00;
	localparam logic [7:0] BIT_RATE_RST = 8'h00;
	// Mask of implemented bits.
	localparam logic [7:0] BIT_RATE_MASK = 8'h77;
	localparam logic [7:0] CTRL_TWO_MASK = 8'h1B;
	// Bits per transfer.
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	// Master shift engine states.
	typedef enum logic [1:0] {
		SB_IDLE = 2'b00,
		SB_LOW = 2'b01,
		SB_HIGH = 2'b10
	} sbsd_state_t;
endpackage : sbsd_pkg

//--- sbsd_rate_div.sv
// Two-stage bit-rate generator: prescaler then power-of-two divider.
// Assumes codes are stable while running; a change does not restart the count.
`timescale 1ns/1ps
module sbsd_rate_div import sbsd_pkg::*; (
	input wire logic clk_i, // System clock.
	input wire logic rst_n_i, // Asynchronous reset, active low.
	input wire logic ce_i, // Clock enable.
	input wire logic run_i, // Count while high, hold in reset when low.
	input wire logic [2:0] presc_code_i, // Prescale code.
	input wire logic [2:0] rate_code_i, // Divider code.
	output logic half_tick_o // Pulse at each half of a bit period.
);
	logic [2:0] presc_cnt;
	logic [7:0] rate_cnt;
	logic presc_tick;
	logic [7:0] half_last;

	// Divider half period is 2 to the code; the last count is that minus one.
	assign half_last = 8'((9'h001 << rate_code_i) - 9'h001);
	assign presc_tick = (presc_cnt == presc_code_i);

	// Prescaler counts code plus one cycles.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			presc_cnt <= 3'h0;
		end else if (ce_i) begin
			if (!run_i || presc_tick) begin
				presc_cnt <= 3'h0;
			end else begin
				presc_cnt <= presc_cnt + 3'h1;
			end
		end
	end

	// Combined division is product of both.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rate_cnt <= 8'h00;
			half_tick_o <= 1'b0;
		end else if (ce_i) begin
			half_tick_o <= 1'b0;
			if (!run_i) begin
				rate_cnt <= 8'h00;
			end else if (presc_tick) begin
				if (rate_cnt >= half_last) begin
					rate_cnt <= 8'h00;
					half_tick_o <= 1'b1;
				end else begin
					rate_cnt <= rate_cnt + 8'h01;
				end
			end
		end
	end
endmodule : sbsd_rate_div

//--- sbsd_chk.sv
// Port checker for the serial rate, status and data core.
// Assumes CE_I high; shadows register writes to know the setup.
`timescale 1ns/1ps
module sbsd_chk import sbsd_pkg::*; (
	input wire logic SYS_CLK_I, // Clock.
	input wire logic RESET_N_I, // Reset, active low.
	input wire logic [2:0] ADDR_I, // Address.
	input wire logic [7:0] WDATA_I, // Write data.
	input wire logic WR_I, // Write strobe.
	input wire logic RD_I, // Read strobe.
	input wire logic [7:0] RDATA_O, // Read data.
	input wire logic IRQ_O, // Interrupt.
	input wire logic SCK_O, // Serial clock.
	input wire logic SCK_OE_O, // Clock enable.
	input wire logic MOSI_OE_O // Data enable.
);
	logic [7:0] c1_q;
	logic [7:0] br_q;
	logic [11:0] hi_cnt;
	logic [11:0] half;
	logic rd_st;
	logic rd_dat;
	logic wr_dat;
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!RESET_N_I);
	// Strobe decodes.
	assign rd_st = RD_I && ADDR_I == ADDR_STATUS;
	assign rd_dat = RD_I && ADDR_I == ADDR_DATA;
	assign wr_dat = WR_I && ADDR_I == ADDR_DATA;
	// Expected half period; a rate change mid-frame is not modelled.
	assign half = ({9'h000, br_q[6:4]} + 12'h001) << br_q[2:0];
	// Shadow of control one and the rate register.
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			c1_q <= CTRL_ONE_RST;
			br_q <= BIT_RATE_RST;
		end else if (WR_I && ADDR_I == ADDR_CTRL_ONE) begin
			c1_q <= WDATA_I;
		end else if (WR_I && ADDR_I == ADDR_BIT_RATE) begin
			br_q <= WDATA_I;
		end
	end
	// Cycles the serial clock has stayed high.
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			hi_cnt <= 12'h000;
		end else begin
			hi_cnt <= SCK_O ? hi_cnt + 12'h001 : 12'h000;
		end
	end
	a_status_unused: assert property (rd_st |=> (RDATA_O & 8'h4F) == 8'h00)
		else $error("status unused bits not zero");
	a_rdata_quiet: assert property (!RD_I |=> RDATA_O == 8'h00)
		else $error("read data outside read slot");
	a_sck_high_time: assert property ($fell(SCK_O) |-> hi_cnt == half)
		else $error("serial clock high time wrong");
	a_sck_idle_low: assert property (!SCK_OE_O |-> !SCK_O)
		else $error("serial clock moves while not driven");
	a_mosi_oe_cfg: assert property ((WR_I && ADDR_I == ADDR_CTRL_ONE) |=> ##1
		MOSI_OE_O == $past(WDATA_I[C1_MASTER] && WDATA_I[C1_ENABLE], 2))
		else $error("data enable does not follow setup");
	a_irq_quiet: assert property ((c1_q[7:5] == 3'h2 || c1_q[7:5] == 3'h0)
		&& $past(c1_q[7]) == 1'b0 && $past(c1_q[5]) == 1'b0 |-> !IRQ_O)
		else $error("interrupt while masked");
	a_rx_clear: assert property (rd_st ##1 RDATA_O[ST_RX_FULL] ##1 rd_dat ##2 rd_st
		|=> !RDATA_O[ST_RX_FULL])
		else $error("receive flag not cleared");
	a_tx_start: assert property (rd_st ##1 (RDATA_O[ST_TX_EMPTY] && c1_q[C1_MASTER]
		&& c1_q[C1_ENABLE]) ##1 wr_dat |-> ##[1:600] SCK_O)
		else $error("no transfer after write");
	c_sck_fall: cover property ($fell(SCK_O));
	c_fault_read: cover property (rd_st ##1 RDATA_O[ST_FAULT]);
	c_irq_rise: cover property ($rose(IRQ_O));
endmodule : sbsd_chk

//--- sbsd_slave_model.sv
// Far-side slave: idle-low clock, samples on rise, shifts on fall.
// Assumes the bench drives its select; later frames echo the last byte.
`timescale 1ns/1ps
module sbsd_slave_model (
	input wire logic sel_n_i, // Select, active low.
	input wire logic sck_i, // Serial clock.
	input wire logic mosi_i, // Data from master.
	input wire logic [7:0] tx_i, // First byte to send.
	output logic miso_o, // Data to master.
	output logic [7:0] rx_o // Last byte taken.
);
	logic [7:0] sh = 8'h00;
	logic [7:0] got = 8'h00;
	int n = 0;
	initial begin
		miso_o = 1'b0;
		rx_o = 8'h00;
	end
	// Select loads the first byte and puts its top bit out.
	always @(negedge sel_n_i) begin
		sh = tx_i;
		n = 0;
		miso_o = sh[7];
	end
	// Sample on the rising edge.
	always @(posedge sck_i) begin
		got = {got[6:0], mosi_i};
	end
	// Echoing the received byte makes a lost second byte visible.
	always @(negedge sck_i) begin
		n = n + 1;
		if (n == 8) begin
			rx_o = got;
			sh = got;
			n = 0;
		end else begin
			sh = {sh[6:0], 1'b0};
		end
		miso_o = sh[7];
	end
	// A released line shows the inverse of its last value.
	always @(posedge sel_n_i) begin
		miso_o = ~miso_o;
	end
endmodule : sbsd_slave_model

//--- tb_top.sv
// Bench for the serial core in master mode against a slave model, then one slave-mode frame.
// Assumes the checker is bound to the top; CE tied high, slave pins driven by the fault and slave scenarios.
`timescale 1ns/1ps
module tb_top import sbsd_pkg::*;;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic ss_n = 1'b1;
	logic sel_n = 1'b1;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] slv_tx = 8'h00;
	logic [7:0] slv_rx;
	logic [7:0] rdata;
	logic [7:0] brs [4] = '{8'h11, 8'h32, 8'h73, 8'h04};
	logic irq, sck, mosi, miso;
	logic sck_in = 1'b0;
	logic mosi_in = 1'b0;
	logic miso_out, miso_oe, ss_out, ss_oe;
	int miscompares = 0;
	int checked = 0;
	// Clock at 40 MHz.
	always #12.5 clk = ~clk;
	sbsd_top DUT (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .CE_I(1'b1), .ADDR_I(addr),
		.WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .IRQ_O(irq),
		.SCK_O(sck), .SCK_OE_O(), .MOSI_O(mosi), .MOSI_OE_O(), .MISO_O(miso_out),
		.MISO_OE_O(miso_oe), .SS_N_O(ss_out), .SS_OE_O(ss_oe), .SCK_I(sck_in),
		.MOSI_I(mosi_in),
		.MISO_I(miso), .SS_N_I(ss_n));
	sbsd_slave_model u_slv (.sel_n_i(sel_n), .sck_i(sck), .mosi_i(mosi),
		.tx_i(slv_tx), .miso_o(miso), .rx_o(slv_rx));
	task automatic results();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : results
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	// Data is taken mid-cycle after the strobe, inside its one valid cycle.
	task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask : rd_reg
	task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp, input string nm);
		logic [7:0] d;
		rd_reg(a, d);
		chk(nm, exp, d);
	endtask : rd_chk
	task automatic wait_rx();
		logic [7:0] s;
		for (int i = 0; i < 1000; i++) begin
			rd_reg(ADDR_STATUS, s);
			if (s[ST_RX_FULL] === 1'b1) return;
		end
		chk("rx wait", 8'h80, s);
		results();
	endtask : wait_rx
	task automatic t_reset();
		rd_chk(ADDR_STATUS, 8'h20, "status rst");
		rd_chk(ADDR_CTRL_ONE, CTRL_ONE_RST, "c1 rst");
		rd_chk(3'h7, 8'h00, "unmapped");
		wr_reg(ADDR_STATUS, 8'hFF);
		rd_chk(ADDR_STATUS, 8'h20, "status wr");
		wr_reg(ADDR_BIT_RATE, 8'hFF);
		rd_chk(ADDR_BIT_RATE, BIT_RATE_MASK, "rate rw");
	endtask : t_reset
	task automatic t_xfer(input logic [7:0] br, input logic [7:0] mt, input logic [7:0] st);
		wr_reg(ADDR_BIT_RATE, br);
		slv_tx <= st;
		sel_n <= 1'b0;
		rd_chk(ADDR_STATUS, 8'h20, "idle");
		wr_reg(ADDR_DATA, mt);
		wait_rx();
		rd_chk(ADDR_DATA, st, "rx data");
		rd_chk(ADDR_STATUS, 8'h20, "rx clr");
		chk("slave rx", mt, slv_rx);
		sel_n <= 1'b1;
	endtask : t_xfer
	task automatic t_unarmed();
		logic [7:0] s;
		// Let an edge pass so the select is not lowered in the step that raised it.
		@(posedge clk);
		slv_tx <= 8'h96;
		sel_n <= 1'b0;
		rd_reg(ADDR_STATUS, s);
		wr_reg(ADDR_DATA, 8'hC3);
		wr_reg(ADDR_DATA, 8'h3C);
		wait_rx();
		rd_chk(ADDR_DATA, 8'h96, "one rx");
		chk("one sent", 8'hC3, slv_rx);
		repeat (200) @(posedge clk);
		rd_chk(ADDR_STATUS, 8'h20, "no second");
		sel_n <= 1'b1;
	endtask : t_unarmed
	task automatic t_queue();
		logic [7:0] s;
		@(posedge clk);
		slv_tx <= 8'h5A;
		sel_n <= 1'b0;
		rd_reg(ADDR_STATUS, s);
		wr_reg(ADDR_DATA, 8'hA1);
		rd_chk(ADDR_STATUS, 8'h20, "fast load");
		wr_reg(ADDR_DATA, 8'hB2);
		rd_chk(ADDR_STATUS, 8'h00, "queued");
		// Both frames must have ended, so the second byte meets a full buffer.
		repeat (700) @(posedge clk);
		rd_chk(ADDR_STATUS, 8'hA0, "overrun");
		rd_chk(ADDR_DATA, 8'h5A, "old kept");
		chk("queue sent", 8'hB2, slv_rx);
		sel_n <= 1'b1;
	endtask : t_queue
	task automatic t_fault();
		wr_reg(ADDR_CTRL_ONE, 8'hD0);
		wr_reg(ADDR_CTRL_TWO, 8'h00);
		ss_n <= 1'b0;
		repeat (6) @(posedge clk);
		ss_n <= 1'b1;
		rd_chk(ADDR_STATUS, 8'h20, "fault off");
		chk("irq off", 8'h00, {7'h00, irq});
		wr_reg(ADDR_CTRL_TWO, 8'h10);
		ss_n <= 1'b0;
		repeat (6) @(posedge clk);
		ss_n <= 1'b1;
		rd_chk(ADDR_STATUS, 8'h30, "fault");
		chk("irq fault", 8'h01, {7'h00, irq});
		wr_reg(ADDR_CTRL_ONE, 8'h70);
		rd_chk(ADDR_STATUS, 8'h20, "fault clr");
		chk("irq tx", 8'h01, {7'h00, irq});
		wr_reg(ADDR_CTRL_ONE, 8'h50);
		repeat (3) @(posedge clk);
		chk("irq masked", 8'h00, {7'h00, irq});
	endtask : t_fault
	// Slave frame: the bench clocks the pins slowly and reads both directions back.
	task automatic t_slave();
		logic [7:0] s;
		logic [7:0] got;
		logic [7:0] mb = 8'h9D;
		wr_reg(ADDR_CTRL_ONE, 8'h52);
		repeat (2) @(negedge clk);
		chk("ss oe", 8'h01, {7'h00, ss_oe});
		chk("ss idle", 8'h01, {7'h00, ss_out});
		wr_reg(ADDR_CTRL_ONE, 8'h40);
		rd_reg(ADDR_STATUS, s);
		wr_reg(ADDR_DATA, 8'h6B);
		ss_n <= 1'b0;
		for (int b = 7; b >= 0; b--) begin
			mosi_in <= mb[b];
			repeat (6) @(posedge clk);
			got[b] = miso_out;
			sck_in <= 1'b1;
			repeat (6) @(posedge clk);
			sck_in <= 1'b0;
		end
		chk("miso oe", 8'h01, {7'h00, miso_oe});
		repeat (6) @(posedge clk);
		ss_n <= 1'b1;
		chk("slave tx", 8'h6B, got);
		rd_chk(ADDR_STATUS, 8'hA0, "slave done");
		rd_chk(ADDR_DATA, 8'h9D, "slave rx");
		rd_chk(ADDR_STATUS, 8'h20, "slave clr");
	endtask : t_slave
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		wr_reg(ADDR_CTRL_ONE, 8'h50);
		for (int i = 0; i < 4; i++) begin
			t_xfer(brs[i], 8'hA5 ^ 8'(i), 8'h3C + 8'(i));
		end
		t_unarmed();
		t_queue();
		t_fault();
		t_slave();
		results();
	end
endmodule : tb_top
bind sbsd_top sbsd_chk u_chk (.SYS_CLK_I(SYS_CLK_I), .RESET_N_I(RESET_N_I),
	.ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
	.IRQ_O(IRQ_O), .SCK_O(SCK_O), .SCK_OE_O(SCK_OE_O), .MOSI_OE_O(MOSI_OE_O));
